/* File: design/agcr_pkg.sv */
// Constants and types for the global configuration register bank.
// Assumes one clock domain and a master-clock enable from a divider.
package agcr_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [4:0] ADDR_IDENT     = 5'h00;
  localparam logic [4:0] ADDR_CFG_ONE   = 5'h01;
  localparam logic [4:0] ADDR_TEST_CFG  = 5'h02;
  localparam logic [4:0] ADDR_REF_AMP   = 5'h03;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FAMILY_BIT      = 5;
  localparam int READBACK_BIT    = 6;
  localparam int CLK_OUT_BIT     = 5;
  localparam int RATE_LSB        = 0;
  localparam int INT_TEST_BIT    = 4;
  localparam int TEST_AMP_BIT    = 2;
  localparam int TEST_RATE_LSB   = 0;
  localparam int REF_4V_BIT      = 5;
  localparam int OPAMP_REF_BIT   = 3;
  localparam int OPAMP_ON_BIT    = 2;

  // ****************************************
  // Fixed bits and reset values
  // ****************************************
  localparam logic [7:0] CFG_ONE_ONES   = 8'h90;
  localparam logic [7:0] CFG_ONE_ZEROS  = 8'h08;
  localparam logic [7:0] TEST_CFG_ONES  = 8'hE0;
  localparam logic [7:0] TEST_CFG_ZEROS = 8'h08;
  localparam logic [7:0] REF_AMP_ONES   = 8'hC0;
  localparam logic [7:0] REF_AMP_ZEROS  = 8'h13;
  localparam logic [7:0] CFG_ONE_RESET  = 8'h94;
  localparam logic [7:0] TEST_CFG_RESET = 8'h00;
  localparam logic [7:0] REF_AMP_RESET  = 8'hE0;

  // ****************************************
  // Rate and test-signal timing
  // ****************************************
  localparam int          MCLK_NOM_KHZ   = 2048;
  localparam int          FASTEST_KSPS   = 64;
  localparam int          BASE_DIV       = MCLK_NOM_KHZ / FASTEST_KSPS;
  localparam logic [2:0]  RATE_RESERVED  = 3'h7;
  localparam logic [1:0]  TEST_SLOW      = 2'h0;
  localparam logic [1:0]  TEST_FAST      = 2'h1;
  localparam logic [1:0]  TEST_UNUSED    = 2'h2;
  localparam logic [1:0]  TEST_DC        = 2'h3;
  localparam int          TEST_SLOW_LOG2 = 21;
  localparam int          TEST_FAST_LOG2 = 20;

  // ****************************************
  // Carrier for the decoded settings
  // ****************************************
  typedef struct packed {
    logic       multi_readback;
    logic       clock_out_en;
    logic [2:0] rate_select;
    logic       word_16bit;
    logic       test_internal;
    logic       test_amp_double;
    logic [1:0] test_rate_select;
    logic       ref_4v;
    logic       opamp_ref_mid;
    logic       opamp_enable;
  } agcr_cfg_s;

endpackage

/* File: design/agcr_regs.sv */
// Global configuration register bank: identification and three config regs.
// Assumes a command decoder on clk issuing byte register reads and writes,
// and mclk_en pulsing once per master clock period.
//
// Operation
// R1: Identification register is constant; writes never change it.
// R2: Bit 5 of identification reports device family; alternate value reserved.
// R3: Must-be-one reserved config bits read back high regardless of writes.
// R4: Must-be-zero reserved config bits read back low regardless of writes.
// R5: Config one bit 6 picks daisy-chain (0) or multi readback (1).
// R6: Config one bit 5 drives oscillator to clock pin when source pin high.
// R7: Rate field sets word size and rate; 111 is reserved; reset 100.
// R8: Rates are fractions of master clock, so they scale with it.
// R9: Config two bit 4 selects internal (1) or external (0) test signals.
// R10: Config two bit 2 selects single or double test amplitude.
// R11: Test field: pulse at mclk/2^21, mclk/2^20, unused, or dc.
// R12: Host writes zero to reserved addresses inside multi-register writes.
// R13: New rate or test settings apply from the completed write onward.
`timescale 1ns/1ps
module agcr_regs #(
  parameter logic [7:0] ID_VALUE = 8'hC5  // Arbitrary identification value
)(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Master clock enable
  input  wire logic                mclk_en,
  // Register access from command decoder
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [4:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  // Pins
  input  wire logic                clock_source_pin,
  output logic                     osc_to_clk_pin,
  // Settings and timing to the converter
  output agcr_pkg::agcr_cfg_s      cfg,
  output logic                     conv_tick,
  output logic                     test_level
);
  import agcr_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]  cfg_one;
  logic [7:0]  test_cfg;
  logic [7:0]  ref_amp;
  logic        src_meta;
  logic        src_sync;
  logic [11:0] rate_cnt;
  logic [20:0] test_cnt;

  // ****************************************
  // Decode
  // ****************************************
  wire         wr_cfg_one  = reg_wr && (reg_addr == ADDR_CFG_ONE);
  wire         wr_test_cfg = reg_wr && (reg_addr == ADDR_TEST_CFG);
  wire         wr_ref_amp  = reg_wr && (reg_addr == ADDR_REF_AMP);
  wire  [7:0]  ident_view  = ID_VALUE & ~(8'h01 << FAMILY_BIT); // R1 R2
  wire  [7:0]  cfg_one_v   = (cfg_one | CFG_ONE_ONES) & ~CFG_ONE_ZEROS; // R3 R4
  wire  [7:0]  test_cfg_v  = (test_cfg | TEST_CFG_ONES) & ~TEST_CFG_ZEROS; // R3 R4
  wire  [7:0]  ref_amp_v   = (ref_amp | REF_AMP_ONES) & ~REF_AMP_ZEROS;
  wire  [7:0]  next_rdata  = (reg_addr == ADDR_IDENT)    ? ident_view :
                             (reg_addr == ADDR_CFG_ONE)  ? cfg_one_v :
                             (reg_addr == ADDR_TEST_CFG) ? test_cfg_v :
                             (reg_addr == ADDR_REF_AMP)  ? ref_amp_v : 8'h00;

  wire  [2:0]  rate_sel    = cfg_one[RATE_LSB +: 3];
  wire  [1:0]  test_sel    = test_cfg[TEST_RATE_LSB +: 2];
  // Rate period in master clocks: BASE_DIV << code
  wire  [12:0] rate_period = 13'(BASE_DIV) << rate_sel; // R7 R8
  wire         rate_wrap   = ({1'b0, rate_cnt} == rate_period - 13'h0001);
  wire  [4:0]  test_log2   = (test_sel == TEST_FAST) ? 5'(TEST_FAST_LOG2)
                                                     : 5'(TEST_SLOW_LOG2);
  wire  [20:0] test_half   = 21'((22'h00_0001 << test_log2) >> 1);
  wire         test_wrap   = (test_cnt == test_half - 21'h00_0001);
  wire         rate_change = wr_cfg_one && (reg_wdata[RATE_LSB +: 3] != rate_sel);
  wire         test_change = wr_test_cfg &&
                             (reg_wdata[TEST_RATE_LSB +: 2] != test_sel);

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_one  <= CFG_ONE_RESET;
      test_cfg <= TEST_CFG_RESET;
      ref_amp  <= REF_AMP_RESET;
    end
    else
    begin
      if (wr_cfg_one)
        cfg_one <= reg_wdata;
      if (wr_test_cfg)
        test_cfg <= reg_wdata;
      if (wr_ref_amp)
        ref_amp <= reg_wdata;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Clock source pin synchroniser
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_meta <= 1'b0;
      src_sync <= 1'b0;
    end
    else
    begin
      src_meta <= clock_source_pin;
      src_sync <= src_meta;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      osc_to_clk_pin <= 1'b0;
    else
      osc_to_clk_pin <= cfg_one[CLK_OUT_BIT] & src_sync; // R6
  end

  // ****************************************
  // Conversion rate divider
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rate_cnt  <= 12'h000;
      conv_tick <= 1'b0;
    end
    else if (rate_change)
    begin
      rate_cnt  <= 12'h000; // R13
      conv_tick <= 1'b0;
    end
    else
    begin
      conv_tick <= mclk_en && rate_wrap;
      if (mclk_en)
        rate_cnt <= rate_wrap ? 12'h000 : rate_cnt + 12'h001; // R8
    end
  end

  // ****************************************
  // Test signal generator
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      test_cnt   <= 21'h00_0000;
      test_level <= 1'b0;
    end
    else if (test_change)
    begin
      test_cnt   <= 21'h00_0000; // R13
      test_level <= 1'b0;
    end
    else
    begin
      case (test_sel)
        TEST_SLOW, TEST_FAST:
        begin
          if (mclk_en)
          begin
            test_cnt <= test_wrap ? 21'h00_0000 : test_cnt + 21'h00_0001;
            if (test_wrap)
              test_level <= ~test_level; // R11
          end
        end
        TEST_DC:
        begin
          test_cnt   <= 21'h00_0000;
          test_level <= 1'b1; // R11
        end
        default:
        begin
          test_cnt   <= 21'h00_0000;
          test_level <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Settings out
  // ****************************************
  assign cfg.multi_readback   = cfg_one[READBACK_BIT]; // R5
  assign cfg.clock_out_en     = cfg_one[CLK_OUT_BIT];
  assign cfg.rate_select      = rate_sel;
  assign cfg.word_16bit       = (rate_sel[2:1] == 2'b00); // R7
  assign cfg.test_internal    = test_cfg[INT_TEST_BIT]; // R9
  assign cfg.test_amp_double  = test_cfg[TEST_AMP_BIT]; // R10
  assign cfg.test_rate_select = test_sel;
  assign cfg.ref_4v           = ref_amp[REF_4V_BIT];
  assign cfg.opamp_ref_mid    = ref_amp[OPAMP_REF_BIT];
  assign cfg.opamp_enable     = ref_amp[OPAMP_ON_BIT];

endmodule

/* File: dv/agcr_regs_assertions.sv */
// Concurrent checks on the register bank ports.
// Assumes binding onto agcr_regs; mclk_en never pulses twice a cycle.
`timescale 1ns/1ps
module agcr_regs_assertions
  import agcr_pkg::*;
#(
  parameter logic [7:0] ID_VALUE = 8'hC5
)(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port
  input wire logic       mclk_en,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  // Pins and settings
  input wire logic       clock_source_pin,
  input wire logic       osc_to_clk_pin,
  input wire agcr_cfg_s  cfg,
  input wire logic       conv_tick,
  input wire logic       test_level
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ident_read_a: assert property (reg_rd && reg_addr == ADDR_IDENT |=> reg_rvalid
    && reg_rdata == (ID_VALUE & 8'hDF)) else $error("bad identification read");
  cfg_one_fixed_a: assert property (reg_rd && reg_addr == ADDR_CFG_ONE |=> reg_rdata[7]
    && reg_rdata[4] && !reg_rdata[3]) else $error("bad fixed bits in config one");
  test_cfg_fixed_a: assert property (reg_rd && reg_addr == ADDR_TEST_CFG |=>
    reg_rdata[7:5] == 3'h7 && !reg_rdata[3]) else $error("bad fixed bits in test config");
  readback_bit_a: assert property (reg_rd && reg_addr == ADDR_CFG_ONE |=>
    reg_rdata[6] == $past(cfg.multi_readback)) else $error("readback bit mismatch");
  clk_out_gate_a: assert property (osc_to_clk_pin |-> $past(cfg.clock_out_en))
    else $error("clock out without enable");
  pin_low_a: assert property (!clock_source_pin [*4] |-> !osc_to_clk_pin)
    else $error("clock out while source pin low");
  word_size_a: assert property (cfg.word_16bit == (cfg.rate_select < 3'h2))
    else $error("word size mismatch");
  tick_gap_a: assert property (conv_tick |=> !conv_tick [*8])
    else $error("conversion ticks too close");
  dc_level_a: assert property ((cfg.test_rate_select == TEST_DC) [*2] |-> test_level)
    else $error("dc test level low");
  unused_level_a: assert property ((cfg.test_rate_select == TEST_UNUSED) [*2] |->
    !test_level) else $error("unused test code drives level");
  cfg_write_a: assert property (reg_wr && reg_addr == ADDR_CFG_ONE |=>
    cfg.rate_select == $past(reg_wdata[2:0]) && cfg.multi_readback == $past(reg_wdata[6]))
    else $error("config one write not applied");
  tick_enable_a: assert property (conv_tick |-> $past(mclk_en))
    else $error("conversion tick without master clock");
endmodule

bind agcr_regs agcr_regs_assertions #(.ID_VALUE(ID_VALUE)) u_chk (.clk(clk), .rst_n(rst_n),
  .mclk_en(mclk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .clock_source_pin(clock_source_pin), .osc_to_clk_pin(osc_to_clk_pin), .cfg(cfg),
  .conv_tick(conv_tick), .test_level(test_level));

/* File: dv/agcr_host_model.sv */
// Host model issuing single byte register reads and writes.
// Assumes the bank answers a read with reg_rvalid one edge later.
`timescale 1ns/1ps
module agcr_host_model (
  // Clock
  input  wire logic       clk,
  // Requests
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [4:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  // Answer
  input  wire logic       reg_rvalid,
  input  wire logic [7:0] reg_rdata
);
  // ****************************************
  // Access tasks
  // ****************************************
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
  end
  // Data passes as given; the bench picks reserved bit values
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
    int i;
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = 1'b0;
    d = 8'h00;
    for (i = 0; i < 4 && !ok; i++)
    begin
      if (reg_rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = reg_rdata;
      end
      else
        @(negedge clk);
    end
  endtask
endmodule

/* File: dv/agcr_regs_tb_top.sv */
// Self-checking bench for the register bank.
// Assumes agcr_pkg and the host model are compiled first.
`timescale 1ns/1ps
module agcr_regs_tb_top;
  import agcr_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       mclk_en;
  logic       half;
  logic       pin;
  logic       wr;
  logic       rd;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       osc;
  agcr_cfg_s  cfg;
  logic       tick;
  logic       tl;
  int         err_count;
  int         tests_run;
  int         n;
  int         r;
  // ****************************************
  // Instances and clocks
  // ****************************************
  // ID_VALUE is arbitrary, bit 5 set on purpose
  agcr_regs #(.ID_VALUE(8'hF7)) dut (.clk(clk), .rst_n(rst_n), .mclk_en(mclk_en),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .clock_source_pin(pin), .osc_to_clk_pin(osc), .cfg(cfg),
    .conv_tick(tick), .test_level(tl));
  agcr_host_model host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rvalid(rvalid), .reg_rdata(rdata));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk)
    mclk_en <= half ? ~mclk_en : 1'b1;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    chk(16'(ok), 16'h0001);
    chk(16'(d), 16'(e));
    if (ok !== 1'b1)
      end_of_test();
  endtask
  task automatic period(output int p);
    int i;
    for (i = 0; i < 5000 && tick !== 1'b1; i++)
      @(negedge clk);
    @(negedge clk);
    for (p = 1; p < 5000 && tick !== 1'b1; p++)
      @(negedge clk);
    if (p >= 5000)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, p, 1);
      end_of_test();
    end
  endtask
  task automatic end_of_test;
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    half = 1'b0;
    pin = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(ADDR_IDENT, 8'hD7);
    rd_chk(ADDR_CFG_ONE, CFG_ONE_RESET);
    rd_chk(ADDR_TEST_CFG, 8'hE0);
    host.wr(ADDR_IDENT, 8'h00);
    rd_chk(ADDR_IDENT, 8'hD7);
    host.wr(ADDR_CFG_ONE, 8'h96);
    rd_chk(ADDR_CFG_ONE, 8'h96);
    host.wr(ADDR_CFG_ONE, 8'hF0);
    rd_chk(ADDR_CFG_ONE, 8'hF0);
    chk(16'({cfg.multi_readback, cfg.clock_out_en}), 16'h0003);
    pin = 1'b1;
    repeat (5) @(negedge clk);
    chk(16'(osc), 16'h0001);
    host.wr(ADDR_CFG_ONE, 8'hD0);
    repeat (2) @(negedge clk);
    chk(16'(osc), 16'h0000);
    host.wr(ADDR_TEST_CFG, 8'hF7);
    rd_chk(ADDR_TEST_CFG, 8'hF7);
    chk(16'({cfg.test_internal, cfg.test_amp_double, cfg.test_rate_select}), 16'h000F);
    repeat (2) @(negedge clk);
    chk(16'(tl), 16'h0001);
    host.wr(ADDR_TEST_CFG, 8'hE2);
    repeat (2) @(negedge clk);
    chk(16'(tl), 16'h0000);
    for (r = 0; r < 7; r++)
    begin
      host.wr(ADDR_CFG_ONE, 8'h90 | 8'(r));
      rd_chk(ADDR_CFG_ONE, 8'h90 | 8'(r));
      chk(16'(cfg.word_16bit), 16'(r < 2));
      period(n);
      chk(16'(n), 16'(32 << r));
    end
    host.wr(ADDR_CFG_ONE, 8'h90);
    half = 1'b1;
    period(n);
    chk(16'(n), 16'h0040);
    half = 1'b0;
    host.wr(5'h0D, 8'h00);
    rd_chk(5'h0D, 8'h00);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    rd_chk(ADDR_CFG_ONE, CFG_ONE_RESET);
    end_of_test();
  end
endmodule
